// *** rtl/ias_regs.sv ***
// Purpose: bus address setting register and three user scratch registers
// Assumes: the bus slave in front gives one-cycle write and read strobes
//          with a register index; inputs are synchronous to i_clk_sys
// Notes:   scratch content is volatile and lost at every reset; the
//          address read view shows the strap code while strap select
//          is set; a low i_ce freezes every flop, so a read or refusal
//          pulse caught by it stands until the enable returns; a
//          refused address write leaves no trace but the refusal pulse
`timescale 1ns/1ps
`default_nettype none
`include "ias_map.svh"

module ias_regs
   import ias_pkg::*;
#(
   parameter int DATA_W  = `IAS_DATA_W,
   parameter int IDX_W   = `IAS_IDX_W,
   parameter int STRAP_W = `IAS_STRAP_W
) (
   input  wire logic                        i_clk_sys,
   input  wire logic                        i_nrst,
   input  wire logic                        i_ce,
   // converter state, from the power train control
   input  wire logic                        i_conv_enabled,
   // measured resistance on the address strap pin, 10 ohm per lsb
   input  wire logic [STRAP_W-1:0]          i_addr_strap_pin,
   // register port from the serial bus slave
   input  wire logic [IDX_W-1:0]            i_reg_idx,
   input  wire logic                        i_wr_en,
   input  wire logic [DATA_W-1:0]           i_wdata,
   input  wire logic                        i_rd_en,
   output logic      [DATA_W-1:0]           o_rdata,
   output logic                             o_rd_valid,
   output logic                             o_wr_refused,
   // address compare for the serial bus slave
   input  wire logic [`IAS_BUS_ADDR_W-1:0]  i_addr_cmp,
   output logic                             o_addr_hit,
   output logic      [`IAS_BUS_ADDR_W-1:0]  o_bus_addr
);

   // one decode serves both the write and the read path
   function automatic ias_reg_t reg_decode(input logic [IDX_W-1:0] idx);
      ias_reg_t sel;
      unique case (idx)
         IDX_W'(`IAS_IDX_ADDR):  sel = IAS_REG_ADDR;
         IDX_W'(`IAS_IDX_SCR_A): sel = IAS_REG_SCR_A;
         IDX_W'(`IAS_IDX_SCR_B): sel = IAS_REG_SCR_B;
         IDX_W'(`IAS_IDX_SCR_C): sel = IAS_REG_SCR_C;
         default:                sel = IAS_REG_NONE;
      endcase
      return sel;
   endfunction

   // low nibble as chosen by the select bit
   function automatic logic [`IAS_NIB_W-1:0] low_nibble(
      input logic                   sel,
      input logic [`IAS_NIB_W-1:0]  field,
      input logic [`IAS_NIB_W-1:0]  strap
   );
      return sel ? strap : field;
   endfunction

   // decode, register state and read path
   ias_reg_t                  wr_sel;
   ias_reg_t                  rd_sel;
   logic                      addr_sel_reg;
   logic [`IAS_NIB_W-1:0]     addr_nib_reg;
   logic [`IAS_NIB_W-1:0]     strap_code;
   logic [`IAS_NIB_W-1:0]     strap_code_reg;
   logic [`IAS_NIB_W-1:0]     nib_eff;
   logic [DATA_W-1:0]         addr_word;
   logic [DATA_W-1:0]         scratch_reg [`IAS_NUM_SCR];
   logic [DATA_W-1:0]         rdata_next;
   logic [`IAS_BUS_ADDR_W-1:0] bus_addr_next;
   logic                      addr_wr;
   logic                      addr_wr_ok;
   logic                      addr_wr_block;
   logic                      wr_sel_bit;
   logic [`IAS_NIB_W-1:0]     wr_nib;
   logic [`IAS_NUM_SCR-1:0]   scr_wr;

   assign wr_sel  = reg_decode(i_reg_idx);
   // a read beside a write sees the value from before that write
   assign rd_sel  = wr_sel;
   assign addr_wr = i_wr_en && (wr_sel == IAS_REG_ADDR);

   // an address write either lands or is refused, never both
   assign addr_wr_ok    = i_ce && addr_wr && !i_conv_enabled;
   assign addr_wr_block = i_ce && addr_wr && i_conv_enabled;

   // only the select bit and the low nibble of a write are kept
   assign wr_sel_bit = i_wdata[`IAS_SEL_BIT];
   assign wr_nib     = i_wdata[`IAS_NIB_HI:`IAS_NIB_LO];

   // one write strobe per scratch word
   for (genvar s = 0; s < `IAS_NUM_SCR; s++) begin : g_scr_wr
      assign scr_wr[s] = i_wr_en
                         && (wr_sel == ias_reg_t'(int'(IAS_REG_SCR_A) + s));
   end

   ias_strap_decode #(
      .STRAP_W (STRAP_W)
   ) u_strap (
      .i_strap_res (i_addr_strap_pin),
      .o_code      (strap_code)
   );

   // strap code is held in a flop so the bus address never sees the
   // divider's combinational settling; it resets to the field's code so
   // the bus answers on the reset address before the pin is sampled
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         strap_code_reg <= `IAS_NIB_RST;
      end else if (i_ce) begin
         strap_code_reg <= strap_code;
      end
   end

   // address setting: only the select bit and the low nibble are stored;
   // the fixed and unimplemented bits have no storage at all
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         addr_sel_reg <= `IAS_SEL_RST;
         addr_nib_reg <= `IAS_NIB_RST;
      end else if (addr_wr_ok) begin
         addr_sel_reg <= wr_sel_bit;
         addr_nib_reg <= wr_nib;
      end
   end

   // a refused write leaves a one-cycle mark for the bus slave
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wr_refused <= 1'b0;
      end else if (i_ce) begin
         o_wr_refused <= addr_wr_block;
      end
   end

   // scratch registers, volatile by design: no path to the
   // nonvolatile_store exists, so reset always brings back zero
   for (genvar g = 0; g < `IAS_NUM_SCR; g++) begin : g_scr
      always_ff @(posedge i_clk_sys or negedge i_nrst) begin
         if (!i_nrst) begin
            scratch_reg[g] <= `IAS_SCR_RST;
         end else if (i_ce && scr_wr[g]) begin
            scratch_reg[g] <= i_wdata;
         end
      end
   end

   assign nib_eff = low_nibble(addr_sel_reg, addr_nib_reg, strap_code_reg);

   // read view of the address setting: field or strap shows in the nibble
   always_comb begin
      addr_word = `IAS_ZERO16;
      // bit 7 and the bits above the select bit keep the zero from here
      addr_word[`IAS_SEL_BIT] = addr_sel_reg;
      addr_word[`IAS_FIX_HI:`IAS_FIX_LO] = `IAS_FIX_VAL;
      addr_word[`IAS_NIB_HI:`IAS_NIB_LO] = nib_eff;
   end

   // unmapped indices read as zero so a host scan finds no ghosts
   always_comb begin
      unique case (rd_sel)
         IAS_REG_ADDR:  rdata_next = addr_word;
         IAS_REG_SCR_A: rdata_next = scratch_reg[0];
         IAS_REG_SCR_B: rdata_next = scratch_reg[1];
         IAS_REG_SCR_C: rdata_next = scratch_reg[2];
         IAS_REG_NONE:  rdata_next = `IAS_ZERO16;
         default:       rdata_next = `IAS_ZERO16;
      endcase
   end

   // read data is captured on the strobe and held until the next read
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rdata <= `IAS_ZERO16;
      end else if (i_ce && i_rd_en) begin
         o_rdata <= rdata_next;
      end
   end

   // a pulse caught by a low i_ce stands until the enable returns
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rd_valid <= 1'b0;
      end else if (i_ce) begin
         o_rd_valid <= i_rd_en;
      end
   end

   // 7-bit slave address: fixed 101 above the chosen nibble
   assign bus_addr_next = {`IAS_FIX_VAL, nib_eff};

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_bus_addr <= {`IAS_FIX_VAL, `IAS_NIB_RST};
      end else if (i_ce) begin
         o_bus_addr <= bus_addr_next;
      end
   end

   // compare against the registered address so a mid-frame change of
   // the strap cannot glitch the match
   assign o_addr_hit = (i_addr_cmp == o_bus_addr);

endmodule
`default_nettype wire

// *** rtl/ias_map.svh ***
// Purpose: offsets, field positions, reset values and strap constants
//          for the bus-address and user scratch register bank
// Assumes: 16-bit registers, reached by register index from the bus
//          slave in front of this bank
// Notes:   definitions only
`ifndef IAS_MAP_SVH
`define IAS_MAP_SVH

// register indices seen by the bus slave
`define IAS_IDX_W            8
`define IAS_IDX_ADDR         8'h00
`define IAS_IDX_SCR_A        8'h01
`define IAS_IDX_SCR_B        8'h02
`define IAS_IDX_SCR_C        8'h03

`define IAS_DATA_W           16
`define IAS_NUM_SCR          3

// bus address setting register layout
`define IAS_SEL_BIT          8
`define IAS_FIX_HI           6
`define IAS_FIX_LO           4
`define IAS_FIX_VAL          3'h5
`define IAS_NIB_HI           3
`define IAS_NIB_LO           0
`define IAS_NIB_W            4
`define IAS_BUS_ADDR_W       7

`define IAS_ADDR_RST         16'h0151
`define IAS_SEL_RST          1'h1
`define IAS_NIB_RST          4'h1
`define IAS_SCR_RST          16'h0000
`define IAS_ZERO16           16'h0000

// strap measurement: one lsb is 10 ohm, a band is 2.56 kOhm wide
`define IAS_STRAP_W          16
`define IAS_STRAP_LSB_OHM    10
`define IAS_BAND_OHM         2560
`define IAS_FULL_OHM         40960
`define IAS_NIB_MAX          4'hf

`endif

// *** rtl/ias_pkg.sv ***
// Purpose: types shared by the address and scratch register bank
// Assumes: ias_map.svh holds every number
// Notes:   register select is decoded once into this enum
`default_nettype none
package ias_pkg;

   typedef enum logic [2:0] {
      IAS_REG_ADDR,
      IAS_REG_SCR_A,
      IAS_REG_SCR_B,
      IAS_REG_SCR_C,
      IAS_REG_NONE
   } ias_reg_t;

endpackage
`default_nettype wire

// *** rtl/ias_strap_decode.sv ***
// Purpose: turn the measured strap resistance into a 4-bit address code
// Assumes: i_strap_res is a resistance in 10 ohm steps, already settled
// Notes:   combinational; the register bank samples the result
`timescale 1ns/1ps
`default_nettype none
`include "ias_map.svh"

module ias_strap_decode
   import ias_pkg::*;
#(
   parameter int STRAP_W  = `IAS_STRAP_W,
   parameter int BAND_LSB = `IAS_BAND_OHM / `IAS_STRAP_LSB_OHM,
   parameter int FULL_LSB = `IAS_FULL_OHM / `IAS_STRAP_LSB_OHM
) (
   input  wire logic [STRAP_W-1:0]     i_strap_res,
   output logic      [`IAS_NIB_W-1:0]  o_code
);

   logic [STRAP_W-1:0] band_idx;

   // sixteen equal bands, lower edge inclusive
   assign band_idx = i_strap_res / STRAP_W'(BAND_LSB);

   // anything past the last band is read as the top code
   always_comb begin
      if (int'(i_strap_res) >= FULL_LSB) begin
         o_code = `IAS_NIB_MAX;
      end else begin
         o_code = band_idx[`IAS_NIB_W-1:0];
      end
   end

endmodule
`default_nettype wire

// *** verif/ias_regs_checker.sv ***
// Purpose: port assertions for the address and scratch bank
// Assumes: answers come one edge after the strobe
// Notes:   bound to every ias_regs instance
`timescale 1ns/1ps
`default_nettype none
module ias_regs_checker #(
   parameter int DATA_W = 16,
   parameter int IDX_W  = 8
) (
   input wire logic              i_clk_sys,
   input wire logic              i_nrst,
   input wire logic              i_ce,
   input wire logic              i_conv_enabled,
   input wire logic [IDX_W-1:0]  i_reg_idx,
   input wire logic              i_wr_en,
   input wire logic              i_rd_en,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic              o_rd_valid,
   input wire logic              o_wr_refused,
   input wire logic [6:0]        i_addr_cmp,
   input wire logic              o_addr_hit,
   input wire logic [6:0]        o_bus_addr
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   wire logic rd = i_ce && i_rd_en;
   wire logic rf = i_ce && i_wr_en && i_reg_idx == 0 && i_conv_enabled;
   property p_fix; o_bus_addr[6:4] == 3'h5; endproperty
   a_fix: assert property (p_fix)
      else $error("fixed address bits wrong");
   property p_hit; o_addr_hit == (i_addr_cmp == o_bus_addr); endproperty
   a_hit: assert property (p_hit)
      else $error("address hit wrong");
   property p_rdv; $past(i_ce) |-> o_rd_valid == $past(i_rd_en); endproperty
   a_rdv: assert property (p_rdv)
      else $error("read valid wrong");
   property p_ref; $past(i_ce) |-> o_wr_refused == $past(rf); endproperty
   a_ref: assert property (p_ref)
      else $error("refusal pulse wrong");
   property p_hold; !rd |=> $stable(o_rdata); endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved");
   property p_radr;
      rd && i_reg_idx == 0 |=> o_rdata[15:9] == 0 && o_rdata[7:4] == 4'h5;
   endproperty
   a_radr: assert property (p_radr)
      else $error("address reg fixed bits wrong");
   property p_unm; rd && i_reg_idx > 3 |=> o_rdata == 0; endproperty
   a_unm: assert property (p_unm)
      else $error("unmapped read not zero");
   property p_ce;
      !i_ce |=> $stable(o_bus_addr) && $stable(o_rd_valid)
                && $stable(o_wr_refused) && $stable(o_rdata);
   endproperty
   a_ce: assert property (p_ce)
      else $error("frozen state moved");
endmodule
bind ias_regs ias_regs_checker #(.DATA_W(DATA_W), .IDX_W(IDX_W)) u_chk (
   .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce),
   .i_conv_enabled(i_conv_enabled), .i_reg_idx(i_reg_idx),
   .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rdata(o_rdata),
   .o_rd_valid(o_rd_valid), .o_wr_refused(o_wr_refused),
   .i_addr_cmp(i_addr_cmp), .o_addr_hit(o_addr_hit), .o_bus_addr(o_bus_addr));
`default_nettype wire

// *** verif/ias_host.sv ***
// Purpose: host end of the register port
// Assumes: one strobe per access, answer one edge later
// Notes:   released lines show the inverse so stale values are not reused
`timescale 1ns/1ps
`default_nettype none
module ias_host (
   input  wire logic        i_clk_sys,
   input  wire logic [15:0] i_rdata,
   input  wire logic        i_rd_valid,
   input  wire logic        i_wr_refused,
   output var  logic [7:0]  o_idx,
   output var  logic        o_wr_en,
   output var  logic [15:0] o_wdata,
   output var  logic        o_rd_en
);
   initial begin
      o_idx = 8'hff;
      o_wr_en = 1'b0;
      o_wdata = 16'h0000;
      o_rd_en = 1'b0;
   end
   // whole 16-bit words only; flag is refusal for writes
   task automatic access(input logic wr, input logic [7:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic f);
      @(posedge i_clk_sys);
      #1;
      o_idx = a;
      o_wdata = d;
      o_wr_en = wr;
      o_rd_en = !wr;
      @(posedge i_clk_sys);
      #1;
      q = i_rdata;
      f = wr ? i_wr_refused : i_rd_valid;
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_idx = ~a;
      o_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// *** verif/ias_regs_bench.sv ***
// Purpose: register tests for the address and scratch bank
// Assumes: strap input in 10 ohm steps, 256 lsb to a band
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module ias_regs_bench;
   logic        clk, nrst, ce, conv, wen, ren, rdv, rfs, hit;
   logic [15:0] strap, wd, rdata;
   logic [7:0]  idx;
   logic [6:0]  cmp, baddr;
   int          n_errors = 0, checks = 0, i;
   ias_regs dut (.i_clk_sys(clk), .i_nrst(nrst), .i_ce(ce),
      .i_conv_enabled(conv), .i_addr_strap_pin(strap), .i_reg_idx(idx),
      .i_wr_en(wen), .i_wdata(wd), .i_rd_en(ren), .o_rdata(rdata),
      .o_rd_valid(rdv), .o_wr_refused(rfs), .i_addr_cmp(cmp),
      .o_addr_hit(hit), .o_bus_addr(baddr));
   ias_host u_host (.i_clk_sys(clk), .i_rdata(rdata), .i_rd_valid(rdv),
      .i_wr_refused(rfs), .o_idx(idx), .o_wr_en(wen), .o_wdata(wd),
      .o_rd_en(ren));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d,
      input logic e);
      logic [15:0] q;
      logic f;
      u_host.access(1'b1, a, d, q, f);
      chk("refused", {15'h0, e}, {15'h0, f});
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] q;
      logic f;
      u_host.access(1'b0, a, 16'h0000, q, f);
      chk("rd_valid", 16'h0001, {15'h0, f});
      chk("rdata", e, q);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #20000;
      n_errors++;
      complete_run();
   end
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      conv = 1'b0;
      strap = 16'h010a;
      cmp = 7'h51;
      repeat (3) @(posedge clk);
      #1;
      nrst = 1'b1;
      rd(8'h00, 16'h0151);
      for (i = 1; i < 4; i++) rd(8'(i), 16'h0000);
      for (i = 1; i < 4; i++) wr(8'(i), 16'ha5c3 ^ 16'(i), 1'b0);
      wr(8'h04, 16'hffff, 1'b0);
      rd(8'h04, 16'h0000);
      for (i = 1; i < 4; i++) rd(8'(i), 16'ha5c3 ^ 16'(i));
      $display("reset and scratch done");
      for (i = 0; i < 32; i++) begin
         strap = 16'((i / 2) * 256 + (i % 2) * 255);
         cmp = (7'h50 + 7'(i / 2)) ^ 7'(i % 2);
         repeat (3) @(posedge clk);
         #1;
         chk("bus_addr", 16'h0050 + 16'(i / 2), {9'h0, baddr});
         chk("hit", 16'(1 - i % 2), {15'h0, hit});
         rd(8'h00, 16'h0150 + 16'(i / 2));
      end
      strap = 16'hffff;
      repeat (3) @(posedge clk);
      #1;
      chk("bus_addr", 16'h005f, {9'h0, baddr});
      $display("strap bands done");
      strap = 16'h0c00;
      wr(8'h00, 16'hfeb3, 1'b0);
      rd(8'h00, 16'h0053);
      chk("bus_addr", 16'h0053, {9'h0, baddr});
      conv = 1'b1;
      wr(8'h00, 16'h0107, 1'b1);
      rd(8'h00, 16'h0053);
      wr(8'h02, 16'h1234, 1'b0);
      rd(8'h02, 16'h1234);
      conv = 1'b0;
      wr(8'h00, 16'h0100, 1'b0);
      rd(8'h00, 16'h015c);
      ce = 1'b0;
      wr(8'h03, 16'hbeef, 1'b0);
      ce = 1'b1;
      rd(8'h03, 16'ha5c0);
      nrst = 1'b0;
      @(posedge clk);
      #1;
      nrst = 1'b1;
      for (i = 1; i < 4; i++) rd(8'(i), 16'h0000);
      rd(8'h00, 16'h015c);
      $display("address and reset done");
      complete_run();
   end
endmodule
`default_nettype wire
